// File: design/cxc_top.sv
/*
 exception sequencer: reset start-up reads, trap and interrupt
 priority, acknowledge cycle, status push and dispatch.
 assumes the core pulses instr_boundary between instructions, holds
 while core_hold is high, and the bus side answers with mem_ready.
*/
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
// Summary of operation
// - reset pin wins over every trap, interrupt and request.
// - reset starts after any cycle where reset pin sampled low.
// - within five cycles bus floats, strobes high, segment number low.
// - segmented: three cycles after release read fcw 0002, pc 0004.
// - nonsegmented: read only pc at 0004 in system mode.
// - unmaskable interrupt is always taken, never masked.
// - vectored interrupt identifier selects routine and is pushed.
// - unvectored identifier pushed only; one common routine.
// - traps have no enable bit.
// - extension instruction with extension bit clear traps.
// - privileged instruction in normal mode traps.
// - every supervisor call traps.
// - segmented part traps on memory fault input regardless of mode.
// - vectored and unvectored accepted only while their bits are set.
// - disabled requests are ignored and never latched.
// - acknowledge loads new flag word; return restores old one.
// - acknowledge cycle only for external requests; 16-bit id read.
// - system (and segmented) mode before acknowledge, old word kept.
// - push pc (offset, segment word), then flag word, then id.
// - trap id is first instruction word; else acknowledge data.
// - priority reset, trap, nmi, segment trap, vectored, unvectored.
module cxc_top
    import cxc_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        reset_pin_n,
    input  wire logic        seg_version,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // core side
    input  wire logic        instr_boundary,
    input  wire logic        ext_instr_decoded,
    input  wire logic        priv_instr_decoded,
    input  wire logic        supervisor_call_instr,
    input  wire logic        return_from_exception,
    input  wire logic [15:0] first_instr_word,
    input  wire logic [15:0] cur_pc,
    input  wire logic [6:0]  cur_segment,
    output logic             core_hold,
    output logic             pc_load,
    output logic [15:0]      pc_value,
    output logic             svc_start,
    output logic [2:0]       svc_kind,
    output logic [15:0]      svc_id,
    output logic             svc_use_id,
    // request pins
    input  wire logic        unmaskable_irq_in,
    input  wire logic        vectored_irq_in,
    input  wire logic        unvectored_irq_in,
    input  wire logic        memory_fault_trap_in,
    // external bus pins
    input  wire logic [15:0] muxed_bus_lines_i,
    output logic [15:0]      muxed_bus_lines_o,
    output logic             muxed_bus_lines_oe,
    output logic [15:0]      bus_addr_out,
    input  wire logic        mem_ready,
    output logic             addr_strobe_n,
    output logic             data_strobe_n,
    output logic             mem_request_n,
    output logic             bus_grant_out_n,
    output logic             multi_micro_out,
    output logic [3:0]       cycle_kind_out,
    output logic [6:0]       segment_number_out,
    output logic             direction_out,
    output logic             width_out,
    output logic             privilege_status_out
);
    // ==========================================================
    // state
    typedef enum logic [3:0] {
        CXC_S_RUN, CXC_S_RST, CXC_S_DLY, CXC_S_RDF, CXC_S_RDP,
        CXC_S_ACK, CXC_S_PPC, CXC_S_PSG, CXC_S_PFW, CXC_S_PID,
        CXC_S_GO
    } cxc_state_t;

    function automatic logic [15:0] cxc_dec(input logic [15:0] v);
        cxc_dec = v - CXC_WORD_STEP;
    endfunction

    function automatic logic is_ext_pick(input cxc_kind_t k);
        is_ext_pick = (k == CXC_EX_NMI) | (k == CXC_EX_MEMORY_FAULT_TRAP_IN)
                      | (k == CXC_EX_VI) | (k == CXC_EX_NVI);
    endfunction

    cxc_state_t  state_q, state_d;
    cxc_kind_t   kind_q, pick;
    logic [15:0] fcw_q, svc_fcw_q, sp_q, saved_fcw_q, id_q, spc_q;
    logic [6:0]  sseg_q;
    logic [1:0]  dly_q;
    logic        nmi_pend_q, nmi_prev_q, acc_q, wb_ack_q;

    // ==========================================================
    // request decode
    wire t_ext  = ext_instr_decoded & ~fcw_q[CXC_FCW_EPA];
    wire t_priv = priv_instr_decoded & ~fcw_q[CXC_FCW_SYS];
    wire t_sc   = supervisor_call_instr;
    wire t_seg  = seg_version & memory_fault_trap_in;
    wire i_vi   = vectored_irq_in & fcw_q[CXC_FCW_VIE];
    wire i_nvi  = unvectored_irq_in & fcw_q[CXC_FCW_UNVECTORED_ENABLE_BIT];
    wire nmi_edge = unmaskable_irq_in & ~nmi_prev_q;
    wire take   = (state_q == CXC_S_RUN) & instr_boundary
                  & (pick != CXC_EX_NONE);
    // only outside requests may overwrite the trap id with bus data
    wire is_ext = is_ext_pick(kind_q);
    wire done   = acc_q & mem_ready;

    always_comb begin
        if (t_ext)
            pick = CXC_EX_TRAP_EXT;
        else if (t_priv)
            pick = CXC_EX_TRAP_PRIV;
        else if (t_sc)
            pick = CXC_EX_TRAP_SC;
        else if (nmi_pend_q | nmi_edge)
            pick = CXC_EX_NMI;
        else if (t_seg)
            pick = CXC_EX_MEMORY_FAULT_TRAP_IN;
        else if (i_vi)
            pick = CXC_EX_VI;
        else if (i_nvi)
            pick = CXC_EX_NVI;
        else
            pick = CXC_EX_NONE;
    end

    // ==========================================================
    // sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            CXC_S_RUN: if (take) state_d = is_ext_pick(pick) ? CXC_S_ACK : CXC_S_PPC;
            CXC_S_RST: state_d = CXC_S_DLY;
            CXC_S_DLY: if (dly_q == CXC_DLY_LAST) begin
                state_d = seg_version ? CXC_S_RDF : CXC_S_RDP;
            end
            CXC_S_RDF: if (done) state_d = CXC_S_RDP;
            CXC_S_RDP: if (done) state_d = CXC_S_RUN;
            CXC_S_ACK: if (done) state_d = CXC_S_PPC;
            CXC_S_PPC: if (done) state_d = seg_version ? CXC_S_PSG : CXC_S_PFW;
            CXC_S_PSG: if (done) state_d = CXC_S_PFW;
            CXC_S_PFW: if (done) state_d = CXC_S_PID;
            CXC_S_PID: if (done) state_d = CXC_S_GO;
            CXC_S_GO:  state_d = CXC_S_RUN;
            default:   state_d = CXC_S_RST;
        endcase
        if (~reset_pin_n)
            state_d = CXC_S_RST;
    end

    // a cycle in the reset hold leaves the pins forced the next edge,
    // well inside five cycles; a shorter pulse still restarts cleanly
    // but the outside is expected to hold it five cycles
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q <= CXC_S_RST;
            dly_q   <= '0;
        end else begin
            state_q <= state_d;
            dly_q   <= (state_q == CXC_S_DLY) ? dly_q + 2'h1 : 2'h0;
        end
    end

    // exception capture
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            kind_q <= CXC_EX_NONE;
            id_q   <= '0;
            spc_q  <= '0;
            sseg_q <= '0;
        end else if (take) begin
            kind_q <= pick;
            id_q   <= first_instr_word;
            spc_q  <= cur_pc;
            sseg_q <= cur_segment;
        end else if ((state_q == CXC_S_ACK) & done & is_ext) begin
            id_q   <= muxed_bus_lines_i;
        end
    end

    // nmi edge pending: a new edge wins over the clear on take
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            nmi_prev_q <= 1'b0;
            nmi_pend_q <= 1'b0;
        end else begin
            nmi_prev_q <= unmaskable_irq_in;
            if (take & (pick == CXC_EX_NMI) & ~(nmi_edge & nmi_pend_q))
                nmi_pend_q <= 1'b0;
            else if (nmi_edge)
                nmi_pend_q <= 1'b1;
        end
    end

    // ==========================================================
    // flag word, service word, stack pointer
    wire wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_q;
    wire wb_wr   = wb_cyc_i & wb_stb_i & wb_ack_q & wb_we_i & wb_sel_i[0] & wb_sel_i[1];
    wire wr_fcw  = wb_wr & (wb_adr_i == CXC_REG_FCW);
    wire wr_svc  = wb_wr & (wb_adr_i == CXC_REG_SVC);
    wire wr_sp   = wb_wr & (wb_adr_i == CXC_REG_SP);
    wire push    = done & ((state_q == CXC_S_PPC) | (state_q == CXC_S_PSG)
                   | (state_q == CXC_S_PFW) | (state_q == CXC_S_PID));

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            fcw_q       <= CXC_FCW_RST;
            saved_fcw_q <= CXC_FCW_RST;
        end else if (state_q == CXC_S_RST) begin
            fcw_q       <= CXC_FCW_RST;
        end else if ((state_q == CXC_S_RDF) & done) begin
            fcw_q       <= muxed_bus_lines_i;
        end else if (take) begin
            saved_fcw_q <= fcw_q;
        end else if (state_q == CXC_S_GO) begin
            fcw_q       <= svc_fcw_q;
        end else if (return_from_exception) begin
            fcw_q       <= saved_fcw_q;
        end else if (wr_fcw) begin
            fcw_q       <= wb_dat_i[15:0];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            svc_fcw_q <= CXC_SVC_RST;
            sp_q      <= CXC_SP_RST;
        end else begin
            if (wr_svc)
                svc_fcw_q <= wb_dat_i[15:0];
            if (push)
                sp_q <= cxc_dec(sp_q);
            else if (wr_sp)
                sp_q <= wb_dat_i[15:0];
        end
    end

    // ==========================================================
    // external bus: one access per state, ended by mem_ready
    wire acc_st = (state_q == CXC_S_RDF) | (state_q == CXC_S_RDP)
                  | (state_q == CXC_S_ACK) | push | (state_q == CXC_S_PPC)
                  | (state_q == CXC_S_PSG) | (state_q == CXC_S_PFW)
                  | (state_q == CXC_S_PID);
    wire wr_st  = (state_q == CXC_S_PPC) | (state_q == CXC_S_PSG)
                  | (state_q == CXC_S_PFW) | (state_q == CXC_S_PID);
    wire [15:0] wdata = (state_q == CXC_S_PPC) ? spc_q :
                        (state_q == CXC_S_PSG) ? {9'h0, sseg_q} :
                        (state_q == CXC_S_PFW) ? saved_fcw_q : id_q;
    wire [15:0] adr   = (state_q == CXC_S_RDF) ? CXC_ADR_FCW :
                        (state_q == CXC_S_RDP) ? CXC_ADR_PC : cxc_dec(sp_q);
    logic [3:0] ck;
    always_comb begin
        case (state_q)
            CXC_S_RST, CXC_S_DLY: ck = CXC_CK_RESET;
            CXC_S_ACK: begin
                case (kind_q)
                    CXC_EX_NMI:  ck = CXC_CK_NMI;
                    CXC_EX_MEMORY_FAULT_TRAP_IN: ck = CXC_CK_MEMORY_FAULT_TRAP_IN;
                    CXC_EX_VI:   ck = CXC_CK_VI;
                    default:     ck = CXC_CK_NVI;
                endcase
            end
            CXC_S_RDF, CXC_S_RDP: ck = CXC_CK_MEM;
            default: ck = wr_st ? CXC_CK_STACK : CXC_CK_IDLE;
        endcase
    end
    wire in_rst = (state_q == CXC_S_RST) | (state_q == CXC_S_DLY);
    wire sysm   = (state_q != CXC_S_RUN) | fcw_q[CXC_FCW_SYS];

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            acc_q                <= 1'b0;
            addr_strobe_n        <= 1'b1;
            data_strobe_n        <= 1'b1;
            mem_request_n        <= 1'b1;
            muxed_bus_lines_oe   <= 1'b0;
            muxed_bus_lines_o    <= '0;
            bus_addr_out         <= '0;
            cycle_kind_out       <= CXC_CK_RESET;
            segment_number_out   <= '0;
            direction_out        <= 1'b1;
            width_out            <= 1'b0;
            privilege_status_out <= 1'b0;
        end else begin
            acc_q                <= acc_st & ~done & (state_d == state_q);
            addr_strobe_n        <= ~(acc_st & ~acc_q);
            data_strobe_n        <= ~(acc_st & ~done);
            mem_request_n        <= ~(acc_st & ~done & (state_q != CXC_S_ACK));
            muxed_bus_lines_oe   <= wr_st & ~done & ~in_rst;
            muxed_bus_lines_o    <= wdata;
            bus_addr_out         <= adr;
            cycle_kind_out       <= ck;
            segment_number_out   <= in_rst ? 7'h00 : sseg_q;
            direction_out        <= ~wr_st;
            width_out            <= 1'b0;
            privilege_status_out <= ~sysm;
        end
    end
    assign bus_grant_out_n = 1'b1;
    assign multi_micro_out = 1'b1;

    // ==========================================================
    // core side
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pc_load    <= 1'b0;
            pc_value   <= '0;
            svc_start  <= 1'b0;
            svc_kind   <= 3'h0;
            svc_id     <= '0;
            svc_use_id <= 1'b0;
        end else begin
            pc_load    <= (state_q == CXC_S_RDP) & done;
            if ((state_q == CXC_S_RDP) & done)
                pc_value <= muxed_bus_lines_i;
            svc_start  <= (state_q == CXC_S_GO);
            if (state_q == CXC_S_GO) begin
                svc_kind   <= kind_q;
                svc_id     <= id_q;
                svc_use_id <= (kind_q == CXC_EX_VI);
            end
        end
    end
    assign core_hold = (state_q != CXC_S_RUN);

    // ==========================================================
    // wishbone: ack one cycle after the strobe, unmapped reads zero
    logic [31:0] rd;
    always_comb begin
        case (wb_adr_i)
            CXC_REG_FCW:   rd = {16'h0000, fcw_q};
            CXC_REG_SVC:   rd = {16'h0000, svc_fcw_q};
            CXC_REG_SP:    rd = {16'h0000, sp_q};
            CXC_REG_STAT:  rd = {25'h0, kind_q, state_q};
            CXC_REG_ID:    rd = {16'h0000, id_q};
            CXC_REG_SAVED: rd = {16'h0000, saved_fcw_q};
            default:       rd = 32'h00000000;
        endcase
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wb_ack_q <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_q <= wb_req;
            if (wb_req)
                wb_dat_o <= rd;
        end
    end
    assign wb_ack_o = wb_ack_q;
endmodule // cxc_top

// File: inc/cxc_pkg.sv
/*
 exception control constants: register map, flag word fields,
 cycle kinds, exception kinds, reset timing.
 assumes a 40 MHz ref_clk and a 32-bit classic wishbone bus.
*/
package cxc_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] CXC_REG_FCW   = 8'h00;
    localparam logic [7:0] CXC_REG_SVC   = 8'h04;
    localparam logic [7:0] CXC_REG_SP    = 8'h08;
    localparam logic [7:0] CXC_REG_STAT  = 8'h0C;
    localparam logic [7:0] CXC_REG_ID    = 8'h10;
    localparam logic [7:0] CXC_REG_SAVED = 8'h14;
    // ==========================================================
    // flag_control_word fields
    localparam int CXC_FCW_SEG  = 15;
    localparam int CXC_FCW_SYS  = 14;
    localparam int CXC_FCW_EPA  = 13;
    localparam int CXC_FCW_VIE  = 12;
    localparam int CXC_FCW_UNVECTORED_ENABLE_BIT = 11;
    localparam logic [15:0] CXC_FCW_RST  = 16'h4000;
    localparam logic [15:0] CXC_SVC_RST  = 16'h4000;
    localparam logic [15:0] CXC_SP_RST   = 16'h0000;
    // ==========================================================
    // reset-time memory locations
    localparam logic [15:0] CXC_ADR_FCW = 16'h0002;
    localparam logic [15:0] CXC_ADR_PC  = 16'h0004;
    localparam logic [15:0] CXC_WORD_STEP = 16'h0002;
    // ==========================================================
    // timing
    localparam int CXC_CLK_MHZ        = 40;
    localparam int CXC_RST_DELAY_CYC  = 3;
    localparam int CXC_RST_FORCE_CYC  = 5;
    localparam logic [1:0] CXC_DLY_LAST = 2'(CXC_RST_DELAY_CYC - 1);
    // ==========================================================
    // cycle_kind_out codes
    localparam logic [3:0] CXC_CK_IDLE  = 4'h0;
    localparam logic [3:0] CXC_CK_RESET = 4'hF;
    localparam logic [3:0] CXC_CK_MEMORY_FAULT_TRAP_IN  = 4'h3;
    localparam logic [3:0] CXC_CK_NMI   = 4'h5;
    localparam logic [3:0] CXC_CK_NVI   = 4'h6;
    localparam logic [3:0] CXC_CK_VI    = 4'h7;
    localparam logic [3:0] CXC_CK_MEM   = 4'h8;
    localparam logic [3:0] CXC_CK_STACK = 4'h9;
    // ==========================================================
    typedef enum logic [2:0] {
        CXC_EX_NONE, CXC_EX_TRAP_EXT, CXC_EX_TRAP_PRIV, CXC_EX_TRAP_SC,
        CXC_EX_NMI, CXC_EX_MEMORY_FAULT_TRAP_IN, CXC_EX_VI, CXC_EX_NVI
    } cxc_kind_t;
endpackage

// File: testbench/cxc_far_model.sv
/*
 far side: memory holding the start-up words, acknowledge responder
 and stack recorder. assumes strobes as described for cxc_top.
*/
`timescale 1ns/1ps
module cxc_far_model
    import cxc_pkg::*;
#(
    parameter logic [15:0] FCW_W = 16'h1800,
    parameter logic [15:0] PC_W  = 16'h0120,
    parameter int          WAITS = 3
)(
    // clock
    input wire logic        ref_clk,
    // bus from the block
    input wire logic        data_strobe_n,
    input wire logic [15:0] bus_addr_out,
    input wire logic [3:0]  cycle_kind_out,
    input wire logic [15:0] muxed_bus_lines_o,
    input wire logic        muxed_bus_lines_oe,
    // bench control
    input wire logic [15:0] ack_id,
    input wire logic        slow,
    // answers
    output logic            mem_ready,
    output logic [15:0]     muxed_bus_lines_i
);
    logic [3:0]  cnt_q  = 4'h0;
    logic [15:0] last_q = 16'h0;
    logic        rdy_q  = 1'b0;
    logic [15:0] pushes [$];
    wire busy = !data_strobe_n && !rdy_q;
    wire drive = !data_strobe_n && !muxed_bus_lines_oe;
    wire ack_k = cycle_kind_out inside {CXC_CK_MEMORY_FAULT_TRAP_IN, CXC_CK_NMI, CXC_CK_NVI, CXC_CK_VI};
    // id word on acknowledge
    wire [15:0] word = ack_k ? ack_id : bus_addr_out == CXC_ADR_FCW ? FCW_W
        : bus_addr_out == CXC_ADR_PC ? PC_W : ~bus_addr_out;
    // released bus shows the inverse, never a stale value
    assign muxed_bus_lines_i = drive ? word : ~last_q;
    assign mem_ready = rdy_q;
    always @(posedge ref_clk) begin
        rdy_q <= busy && (cnt_q >= (slow ? 4'(WAITS) : 4'h0));
        cnt_q <= busy ? cnt_q + 4'h1 : 4'h0;
        if (drive)
            last_q <= word;
        if (rdy_q && muxed_bus_lines_oe)
            pushes.push_back(muxed_bus_lines_o);
    end
endmodule // cxc_far_model

// File: testbench/cxc_top_checker.sv
/*
 checker for cxc_top: pin reset forcing, start-up reads, acknowledge,
 push and dispatch relations. assumes it is bound to cxc_top.
*/
`timescale 1ns/1ps
module cxc_top_checker
    import cxc_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        reset_pin_n,
    input wire logic        seg_version,
    // dispatch
    input wire logic        svc_start,
    input wire logic [2:0]  svc_kind,
    input wire logic        svc_use_id,
    // bus pins
    input wire logic        muxed_bus_lines_oe,
    input wire logic [15:0] bus_addr_out,
    input wire logic        addr_strobe_n,
    input wire logic        data_strobe_n,
    input wire logic        mem_request_n,
    input wire logic        bus_grant_out_n,
    input wire logic        multi_micro_out,
    input wire logic [3:0]  cycle_kind_out,
    input wire logic [6:0]  segment_number_out,
    input wire logic        privilege_status_out,
    input wire logic        direction_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ==========================================================
    // helpers
    wire ack_cyc = !data_strobe_n
        && (cycle_kind_out inside {CXC_CK_MEMORY_FAULT_TRAP_IN, CXC_CK_NMI, CXC_CK_NVI, CXC_CK_VI});
    // ==========================================================
    // assertions
    a_pin_forced: assert property (
        !reset_pin_n [*3] |-> addr_strobe_n && data_strobe_n && mem_request_n
            && !muxed_bus_lines_oe && cycle_kind_out == CXC_CK_RESET
            && segment_number_out == 7'h00)
        else $error("pins not forced during pin reset");
    a_fixed_high: assert property (
        bus_grant_out_n && multi_micro_out)
        else $error("grant or multi micro pin low");
    a_start_quiet: assert property (
        $rose(reset_pin_n) |-> addr_strobe_n [*3])
        else $error("bus access too soon after pin release");
    a_seg_reads: assert property (
        $rose(reset_pin_n) && seg_version
            |-> ##[3:12] (!addr_strobe_n && bus_addr_out == CXC_ADR_FCW))
        else $error("segmented start-up flag word read missing");
    a_nonseg_read: assert property (
        $rose(reset_pin_n) && !seg_version
            |-> ##[3:12] (!addr_strobe_n && bus_addr_out == CXC_ADR_PC))
        else $error("nonsegmented start-up pc read missing");
    a_ack_no_mem_request_n: assert property (
        ack_cyc |-> mem_request_n)
        else $error("memory request during acknowledge");
    a_ack_system: assert property (
        ack_cyc |-> !privilege_status_out)
        else $error("acknowledge outside system mode");
    a_push_drives: assert property (
        !data_strobe_n && cycle_kind_out == CXC_CK_STACK
            |-> muxed_bus_lines_oe && !direction_out)
        else $error("stack write without bus drive");
    a_vector_use: assert property (
        svc_start |-> svc_use_id == (svc_kind == CXC_EX_VI))
        else $error("identifier dispatch wrong for kind");
endmodule // cxc_top_checker

bind cxc_top cxc_top_checker u_chk (.*);

// File: testbench/tb_cxc_top.sv
/*
 bench for cxc_top: start-up, every exception kind, priority, masking
 and flag word restore. assumes cxc_far_model answers the bus.
*/
`timescale 1ns/1ps
module tb_cxc_top
    import cxc_pkg::*;
;
    localparam logic [15:0] FCW_W = 16'h1800;
    localparam logic [15:0] PC_W  = 16'h0120;
    logic        ref_clk, reset, reset_pin_n, seg_version, wb_cyc_i, wb_stb_i, wb_we_i;
    logic        wb_ack_o, instr_boundary, ext_instr_decoded, priv_instr_decoded, slow;
    logic        supervisor_call_instr, return_from_exception, core_hold, pc_load;
    logic        svc_start, svc_use_id, unmaskable_irq_in, vectored_irq_in, mem_ready;
    logic        unvectored_irq_in, memory_fault_trap_in, muxed_bus_lines_oe, width_out;
    logic        addr_strobe_n, data_strobe_n, mem_request_n, bus_grant_out_n;
    logic        multi_micro_out, direction_out, privilege_status_out;
    logic [2:0]  svc_kind;
    logic [3:0]  wb_sel_i, cycle_kind_out;
    logic [6:0]  cur_segment, segment_number_out;
    logic [7:0]  wb_adr_i;
    logic [15:0] first_instr_word, cur_pc, pc_value, svc_id, muxed_bus_lines_i;
    logic [15:0] muxed_bus_lines_o, bus_addr_out, ack_id, rd;
    logic [31:0] wb_dat_i, wb_dat_o;
    int          miscompares = 0;
    int          comparisons = 0;
    cxc_top uut (.*);
    cxc_far_model #(.FCW_W(FCW_W), .PC_W(PC_W)) u_far (.*);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // ==========================================================
    // tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d);
        int n = 0;
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        wb_adr_i <= a;
        wb_dat_i <= {16'h0, d};
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1 && ++n < 40);
        rd = wb_dat_o[15:0];
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (n >= 40) miscompares++;
    endtask
    task automatic boot(input logic address_mode_flag);
        int n = 0;
        @(posedge ref_clk);
        reset_pin_n <= 1'b0;
        seg_version <= address_mode_flag;
        repeat (5) @(posedge ref_clk);
        reset_pin_n <= 1'b1;
        do @(negedge ref_clk); while (core_hold !== 1'b0 && ++n < 100);
        chk({15'h0, core_hold}, 16'h0);
        chk(pc_value, PC_W);
    endtask
    task automatic run(input logic [6:0] req, input cxc_kind_t ek, input logic [15:0] id);
        int n = 0;
        logic [15:0] old;
        logic [15:0] exp_id;
        wb(1'b0, CXC_REG_FCW, 16'h0);
        old = rd;
        exp_id = (ek >= CXC_EX_NMI) ? ~id : id;
        u_far.pushes.delete();
        @(posedge ref_clk);
        {unvectored_irq_in, vectored_irq_in, memory_fault_trap_in, unmaskable_irq_in,
            supervisor_call_instr, priv_instr_decoded, ext_instr_decoded} <= req;
        {first_instr_word, ack_id, instr_boundary} <= {id, ~id, 1'b1};
        @(posedge ref_clk);
        {instr_boundary, unmaskable_irq_in} <= 2'b00;
        {supervisor_call_instr, priv_instr_decoded, ext_instr_decoded} <= 3'h0;
        do @(negedge ref_clk); while (svc_start !== 1'b1 && ++n < 200);
        if (ek == CXC_EX_NONE)
            chk({15'h0, svc_start}, 16'h0);
        else begin
            chk({15'h0, svc_start}, 16'h1);
            chk({13'h0, svc_kind}, {13'h0, ek});
            chk(svc_id, exp_id);
            chk({15'h0, svc_use_id}, {15'h0, ek == CXC_EX_VI});
        end
        @(posedge ref_clk);
        // vectored, unvectored and memory fault levels hold until dispatched
        {unvectored_irq_in, vectored_irq_in, memory_fault_trap_in} <= 3'h0;
        if (ek != CXC_EX_NONE) begin
            n = u_far.pushes.size();
            chk(16'(n), seg_version ? 16'h4 : 16'h3);
            chk(u_far.pushes[0], cur_pc);
            chk(u_far.pushes[n - 2], old);
            if (seg_version) chk(u_far.pushes[1], {9'h0, cur_segment});
            chk(u_far.pushes[n - 1], exp_id);
            wb(1'b0, CXC_REG_SAVED, 16'h0);
            chk(rd, old);
            wb(1'b0, CXC_REG_FCW, 16'h0);
            chk(rd, CXC_SVC_RST);
            @(posedge ref_clk);
            return_from_exception <= 1'b1;
            @(posedge ref_clk);
            return_from_exception <= 1'b0;
            wb(1'b0, CXC_REG_FCW, 16'h0);
            chk(rd, old);
        end
    endtask
    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ==========================================================
    // sequence
    initial begin
        {reset, reset_pin_n, seg_version, slow} = 4'b1010;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = {43'h0, 4'hF};
        {instr_boundary, ext_instr_decoded, priv_instr_decoded} = 3'h0;
        {supervisor_call_instr, return_from_exception, unmaskable_irq_in} = 3'h0;
        {vectored_irq_in, unvectored_irq_in, memory_fault_trap_in} = 3'h0;
        {first_instr_word, ack_id, cur_pc, cur_segment} = {32'h0, 16'h0300, 7'h05};
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        boot(1'b1);
        wb(1'b0, CXC_REG_FCW, 16'h0);
        chk(rd, FCW_W);
        wb(1'b0, 8'h1C, 16'h0);
        chk(rd, 16'h0);
        $display("test startup done");
        for (int k = 1; k < 8; k++) begin
            slow = k[0];
            run(7'(1 << (k - 1)), cxc_kind_t'(k), 16'h1000 + 16'(k));
        end
        $display("test kinds done");
        run(7'h2A, CXC_EX_TRAP_PRIV, 16'h2001);
        run(7'h00, CXC_EX_NMI, 16'h2002);
        $display("test priority done");
        wb(1'b1, CXC_REG_FCW, 16'h0000);
        run(7'h60, CXC_EX_NONE, 16'h3001);
        run(7'h08, CXC_EX_NMI, 16'h3002);
        run(7'h10, CXC_EX_MEMORY_FAULT_TRAP_IN, 16'h3003);
        wb(1'b1, CXC_REG_FCW, FCW_W);
        run(7'h00, CXC_EX_NONE, 16'h3004);
        run(7'h60, CXC_EX_VI, 16'h3005);
        $display("test masking done");
        boot(1'b0);
        wb(1'b0, CXC_REG_FCW, 16'h0);
        chk(rd, CXC_FCW_RST);
        run(7'h04, CXC_EX_TRAP_SC, 16'h4001);
        $display("test nonsegmented done");
        results();
    end
    initial begin
        // the run needs about a thousand cycles; far beyond that is a hang
        #(25.0 * 30000);
        miscompares++;
        results();
    end
endmodule // tb_cxc_top
